// [hdl/spd_chan.sv]
// Purpose: one dma channel with ping-pong buffers a and b
// Assumes: memory port answers each request with one ack pulse
// Notes: rx keeps a count per buffer, tx shares one count
`timescale 1ns/1ns
module spd_chan #(
   parameter bit IS_RX = 1'b0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // software controls
   input wire logic chan_rst_i,
   input wire logic [1:0] load_i,
   input wire logic [1:0] end_we_i,
   input wire logic [1:0] beg_we_i,
   input wire logic [1:0] cnt_we_i,
   input wire logic [spd_pkg::SPD_MW-1:0] wdat_i,
   // fifo side
   input wire logic fifo_ok_i,
   // memory side
   output logic mem_req_o,
   output logic [spd_pkg::SPD_MW-1:0] mem_addr_o,
   input wire logic mem_ack_i,
   output logic byte_o,
   // state
   output logic [1:0] loaded_o,
   output logic act_o,
   output logic [1:0] unload_o,
   output logic [spd_pkg::SPD_MW-1:0] beg_a_o,
   output logic [spd_pkg::SPD_MW-1:0] beg_b_o,
   output logic [spd_pkg::SPD_MW-1:0] end_a_o,
   output logic [spd_pkg::SPD_MW-1:0] end_b_o,
   output logic [spd_pkg::SPD_MW-1:0] cnt_a_o,
   output logic [spd_pkg::SPD_MW-1:0] cnt_b_o
);
   import spd_pkg::*;
   typedef struct packed {
      logic [1:0] ld;
      logic act;
      logic [1:0][SPD_MW-1:0] beg;
      logic [1:0][SPD_MW-1:0] fin;
      logic [1:0][SPD_MW-1:0] cnt;
      logic req;
      logic [1:0] unl;
      logic bm;
   } spd_ch_t;
   spd_ch_t st_reg, st_next;
   logic [1:0] over;
   // overflow-safe compare: one extra bit so start+count never wraps
   function automatic logic spd_past(input logic [SPD_MW-1:0] b, input logic [SPD_MW-1:0] c,
                                     input logic [SPD_MW-1:0] e);
      spd_past = ({1'b0, b} + {1'b0, c}) > {1'b0, e};
   endfunction
   always_comb begin
      logic cb;
      st_next = st_reg;
      st_next.unl = 2'b00;
      st_next.bm = 1'b0;
      cb = st_reg.act;
      for (int i = 0; i < 2; i++) begin
         if (beg_we_i[i]) st_next.beg[i] = wdat_i;
         if (end_we_i[i]) st_next.fin[i] = wdat_i;
      end
      // byte moved: address start+count, advance count
      if (st_reg.req && mem_ack_i) begin
         st_next.req = 1'b0;
         st_next.bm = 1'b1;
         if (IS_RX) st_next.cnt[cb] = st_reg.cnt[cb] + 1'b1;
         else st_next.cnt[0] = st_reg.cnt[0] + 1'b1;
      end else if (!st_reg.req && st_reg.ld[cb] && fifo_ok_i && !over[cb]) begin
         st_next.req = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         if (IS_RX && cnt_we_i[i]) begin
            st_next.cnt[i] = wdat_i;
            st_next.ld[i] = 1'b1;
         end
         if (load_i[i]) begin
            st_next.ld[i] = 1'b1;
            if (IS_RX) st_next.cnt[i] = '0;
            else st_next.cnt[0] = '0;
         end
      end
      // unload check uses registered end/count, so early unload by writes comes one cycle after the write
      for (int i = 0; i < 2; i++) begin
         if (st_reg.ld[i] && over[i] && !(st_reg.req && cb == i[0]) && !load_i[i]
             && !cnt_we_i[i]) begin
            st_next.ld[i] = 1'b0;
            st_next.unl[i] = 1'b1;
            if (!IS_RX && cb == i[0]) st_next.cnt[0] = st_reg.cnt[0];
         end
      end
      // ping-pong: move to the other buffer once active one is idle
      if (!st_next.ld[cb] && st_next.ld[~cb] && !st_next.req) begin
         st_next.act = ~cb;
         if (!IS_RX) st_next.cnt[0] = '0;
      end
      if (chan_rst_i) begin
         st_next.ld = 2'b00;
         st_next.act = 1'b0;
         st_next.req = 1'b0;
         st_next.cnt = '0;
      end
   end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         // tx count belongs to the active buffer only; a pending tx buffer sits at offset zero
         over[i] = spd_past(st_reg.beg[i],
                            IS_RX ? st_reg.cnt[i] :
                            (st_reg.act == i[0] ? st_reg.cnt[0] : {SPD_MW{1'b0}}),
                            st_reg.fin[i]);
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) st_reg <= '0;
      else st_reg <= st_next;
   end
   assign mem_req_o = st_reg.req;
   assign mem_addr_o = st_reg.beg[st_reg.act] + (IS_RX ? st_reg.cnt[st_reg.act] : st_reg.cnt[0]);
   assign byte_o = st_reg.bm;
   assign loaded_o = st_reg.ld;
   assign act_o = st_reg.act;
   assign unload_o = st_reg.unl;
   assign beg_a_o = st_reg.beg[0];
   assign beg_b_o = st_reg.beg[1];
   assign end_a_o = st_reg.fin[0];
   assign end_b_o = st_reg.fin[1];
   assign cnt_a_o = st_reg.cnt[0];
   assign cnt_b_o = st_reg.cnt[1];
   a_chan_reset: assert property (@(posedge clk_i) disable iff (rst_i)
      chan_rst_i |=> loaded_o == 2'b00 && !mem_req_o)
      else $error("channel reset left a buffer loaded");
   a_load_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      load_i[0] && !chan_rst_i |=> loaded_o[0])
      else $error("load did not load buffer a");
   a_unload_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      unload_o[0] |-> !loaded_o[0] && $past(loaded_o[0]))
      else $error("unload pulse without a loaded buffer");
   a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
      byte_o && !$past(chan_rst_i) && !$past(load_i[act_o]) && !IS_RX
      |-> cnt_a_o == $past(cnt_a_o) + 16'h0001 || !$past(loaded_o[act_o]))
      else $error("tx count did not advance by one");
endmodule

// [hdl/spd_pkg.sv]
// Purpose: shared constants for the serial ping-pong dma channel block
// Assumes: classic wishbone register port, 32-bit data, byte addresses
// Notes: offsets other than the status register are local choices
package spd_pkg;
   localparam int SPD_AW = 16;
   localparam int SPD_MW = 16;
   localparam logic [SPD_AW-1:0] SPD_ISR_OFF = 16'ha808;
   localparam logic [SPD_AW-1:0] SPD_DMACR_OFF = 16'ha900;
   localparam logic [SPD_AW-1:0] SPD_TXA_BEG_OFF = 16'ha904;
   localparam logic [SPD_AW-1:0] SPD_TXA_END_OFF = 16'ha908;
   localparam logic [SPD_AW-1:0] SPD_TXB_BEG_OFF = 16'ha90c;
   localparam logic [SPD_AW-1:0] SPD_TXB_END_OFF = 16'ha910;
   localparam logic [SPD_AW-1:0] SPD_RXA_BEG_OFF = 16'ha914;
   localparam logic [SPD_AW-1:0] SPD_RXA_END_OFF = 16'ha918;
   localparam logic [SPD_AW-1:0] SPD_RXB_BEG_OFF = 16'ha91c;
   localparam logic [SPD_AW-1:0] SPD_RXB_END_OFF = 16'ha920;
   localparam logic [SPD_AW-1:0] SPD_TXCNT_OFF = 16'ha924;
   localparam logic [SPD_AW-1:0] SPD_RXCNTA_OFF = 16'ha928;
   localparam logic [SPD_AW-1:0] SPD_RXCNTB_OFF = 16'ha92c;
   localparam logic [SPD_AW-1:0] SPD_DMASR_OFF = 16'ha930;
   // dma control bits
   localparam int SPD_CR_TXLA = 0;
   localparam int SPD_CR_TXLB = 1;
   localparam int SPD_CR_RXLA = 2;
   localparam int SPD_CR_RXLB = 3;
   localparam int SPD_CR_TX_CHANNEL_RESET = 4;
   localparam int SPD_CR_RX_CHANNEL_RESET = 5;
   // status bit positions
   localparam int SPD_RX_NOT_EMPTY_FLAG = 0;
   localparam int SPD_TXE = 1;
   localparam int SPD_IDLE = 2;
   localparam int SPD_OVR = 3;
   localparam int SPD_UDR = 4;
   localparam int SPD_BRF = 5;
   localparam int SPD_BTF = 6;
   localparam int SPD_CMDF = 7;
   localparam int SPD_NACK = 8;
   localparam int SPD_RXULA = 9;
   localparam int SPD_RXULB = 10;
   localparam int SPD_TXULA = 11;
   localparam int SPD_TXULB = 12;
   localparam int SPD_FE = 13;
   localparam int SPD_PE = 14;
   localparam logic [14:0] SPD_ISR_RST = 15'h0000;
   localparam logic [SPD_MW-1:0] SPD_ADDR_RST = 16'h0000;
   typedef enum logic [2:0] {
      SPD_IDLE_ST = 3'b001,
      SPD_REQ_ST = 3'b010,
      SPD_DONE_ST = 3'b100
   } spd_mst_t;
endpackage

// [hdl/spd_top.sv]
// Purpose: serial controller tx and rx ping-pong dma with interrupt status register
// Assumes: classic wishbone slave, one clock, synchronous active-high reset
// Notes: fifo and shifter events arrive as one-cycle pulses
// Function
// - each channel has buffers a and b and swaps automatically without gap
// - channel reset bit returns channel and both buffers to idle
// - buffer defined by start and inclusive end address registers
// - per-buffer load bits in control register make buffer pending or active
// - end address writable while loaded, takes effect immediately
// - count holds offset of next byte, advances by one per byte
// - tx has one shared count, rx has a count per buffer
// - count kept until buffer loaded or reset; any tx load clears tx count
// - rx count writable; writing an idle buffer's count also loads it
// - buffer unloads when start plus count exceeds end
// - end or count writes can trigger early unload
// - unload sets pending bit 12 txb, 11 txa, 10 rxb, 9 rxa
// - parity error sets bit 14, framing error sets bit 13
// - i2c nack sets bit 8
// - i2c start or stop done sets bit 7, cleared by writing zero
// - i2c byte sent sets bit 6, byte received sets bit 5
// - underrun sets bit 4
// - overrun sets bit 3, new byte discarded
// - idle line sets bit 2
// - tx data register empty sets bit 1
// - rx data available sets bit 0
// - status resets to zero, bits 31 to 15 reserved
// - rx error character offset recorded in error offset register; this block has no error offset register
// - unload flag interrupts only when its enable bit is set; this block has no enable bits and no interrupt output
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
module spd_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [spd_pkg::SPD_AW-1:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // serial events, one-cycle pulses
   input wire logic par_err_i,
   input wire logic frm_err_i,
   input wire logic nack_i,
   input wire logic cmd_done_i,
   input wire logic byte_sent_i,
   input wire logic byte_got_i,
   input wire logic underrun_i,
   input wire logic overrun_i,
   input wire logic idle_line_i,
   input wire logic tx_empty_i,
   input wire logic rx_not_empty_i,
   // fifo handshakes
   input wire logic tx_fifo_room_i,
   output logic tx_fifo_push_o,
   output logic [7:0] tx_fifo_data_o,
   input wire logic rx_fifo_avail_i,
   input wire logic [7:0] rx_fifo_data_i,
   output logic rx_fifo_pop_o,
   // ram port
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [spd_pkg::SPD_MW-1:0] mem_addr_o,
   output logic [7:0] mem_wdata_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_ack_i
);
   import spd_pkg::*;
   typedef struct packed {
      logic ack;
      logic [31:0] rd;
      logic [14:0] isr;
      logic [7:0] txd;
      logic push;
      logic pop;
      logic gnt_rx;
      logic busy;
   } spd_top_t;
   spd_top_t st_reg, st_next;
   logic wr, rd;
   logic [5:0] cr_wr;
   logic [1:0] tx_end_we, tx_beg_we, rx_end_we, rx_beg_we, rx_cnt_we;
   logic tx_req, rx_req, tx_ack, rx_ack, tx_bm, rx_bm;
   logic [SPD_MW-1:0] tx_addr, rx_addr;
   logic [1:0] tx_ld, rx_ld, tx_unl, rx_unl;
   logic tx_act, rx_act;
   logic [SPD_MW-1:0] txba, txbb, txea, txeb, txc, txcb_unused;
   logic [SPD_MW-1:0] rxba, rxbb, rxea, rxeb, rxca, rxcb;
   logic [14:0] hw_set;
   logic [31:0] rdv;

   function automatic logic spd_hit(input logic [SPD_AW-1:0] a, input logic [SPD_AW-1:0] off);
      spd_hit = (a == off);
   endfunction

   // one-cycle ack: request held by master until ack, dropped next cycle
   assign wr = cyc_i && stb_i && we_i && !st_reg.ack;
   assign rd = cyc_i && stb_i && !we_i && !st_reg.ack;
   always_comb begin
      cr_wr = '0;
      tx_end_we = '0;
      tx_beg_we = '0;
      rx_end_we = '0;
      rx_beg_we = '0;
      rx_cnt_we = '0;
      if (wr && sel_i[0]) begin
         if (spd_hit(adr_i, SPD_DMACR_OFF)) cr_wr = dat_i[5:0];
         else if (spd_hit(adr_i, SPD_TXA_BEG_OFF)) tx_beg_we[0] = 1'b1;
         else if (spd_hit(adr_i, SPD_TXB_BEG_OFF)) tx_beg_we[1] = 1'b1;
         else if (spd_hit(adr_i, SPD_TXA_END_OFF)) tx_end_we[0] = 1'b1;
         else if (spd_hit(adr_i, SPD_TXB_END_OFF)) tx_end_we[1] = 1'b1;
         else if (spd_hit(adr_i, SPD_RXA_BEG_OFF)) rx_beg_we[0] = 1'b1;
         else if (spd_hit(adr_i, SPD_RXB_BEG_OFF)) rx_beg_we[1] = 1'b1;
         else if (spd_hit(adr_i, SPD_RXA_END_OFF)) rx_end_we[0] = 1'b1;
         else if (spd_hit(adr_i, SPD_RXB_END_OFF)) rx_end_we[1] = 1'b1;
         else if (spd_hit(adr_i, SPD_RXCNTA_OFF)) rx_cnt_we[0] = 1'b1;
         else if (spd_hit(adr_i, SPD_RXCNTB_OFF)) rx_cnt_we[1] = 1'b1;
      end
   end

   // rx gets the ram port first; tx waits, which only delays a byte
   assign rx_ack = mem_ack_i && st_reg.gnt_rx;
   assign tx_ack = mem_ack_i && !st_reg.gnt_rx;

   spd_chan #(.IS_RX(1'b0)) u_tx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .chan_rst_i(cr_wr[SPD_CR_TX_CHANNEL_RESET]),
      .load_i({cr_wr[SPD_CR_TXLB], cr_wr[SPD_CR_TXLA]}),
      .end_we_i(tx_end_we),
      .beg_we_i(tx_beg_we),
      .cnt_we_i(2'b00),
      .wdat_i(dat_i[SPD_MW-1:0]),
      .fifo_ok_i(tx_fifo_room_i && !st_reg.push),
      .mem_req_o(tx_req),
      .mem_addr_o(tx_addr),
      .mem_ack_i(tx_ack),
      .byte_o(tx_bm),
      .loaded_o(tx_ld),
      .act_o(tx_act),
      .unload_o(tx_unl),
      .beg_a_o(txba),
      .beg_b_o(txbb),
      .end_a_o(txea),
      .end_b_o(txeb),
      .cnt_a_o(txc),
      .cnt_b_o(txcb_unused)
   );
   spd_chan #(.IS_RX(1'b1)) u_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .chan_rst_i(cr_wr[SPD_CR_RX_CHANNEL_RESET]),
      .load_i({cr_wr[SPD_CR_RXLB], cr_wr[SPD_CR_RXLA]}),
      .end_we_i(rx_end_we),
      .beg_we_i(rx_beg_we),
      .cnt_we_i(rx_cnt_we),
      .wdat_i(dat_i[SPD_MW-1:0]),
      .fifo_ok_i(rx_fifo_avail_i && !st_reg.pop),
      .mem_req_o(rx_req),
      .mem_addr_o(rx_addr),
      .mem_ack_i(rx_ack),
      .byte_o(rx_bm),
      .loaded_o(rx_ld),
      .act_o(rx_act),
      .unload_o(rx_unl),
      .beg_a_o(rxba),
      .beg_b_o(rxbb),
      .end_a_o(rxea),
      .end_b_o(rxeb),
      .cnt_a_o(rxca),
      .cnt_b_o(rxcb)
   );

   // hardware set sources for the status register
   always_comb begin
      hw_set = '0;
      hw_set[SPD_PE] = par_err_i;
      hw_set[SPD_FE] = frm_err_i;
      hw_set[SPD_TXULB] = tx_unl[1];
      hw_set[SPD_TXULA] = tx_unl[0];
      hw_set[SPD_RXULB] = rx_unl[1];
      hw_set[SPD_RXULA] = rx_unl[0];
      hw_set[SPD_NACK] = nack_i;
      hw_set[SPD_CMDF] = cmd_done_i;
      hw_set[SPD_BTF] = byte_sent_i;
      hw_set[SPD_BRF] = byte_got_i;
      hw_set[SPD_UDR] = underrun_i;
      hw_set[SPD_OVR] = overrun_i;
      hw_set[SPD_IDLE] = idle_line_i;
      hw_set[SPD_TXE] = tx_empty_i;
      hw_set[SPD_RX_NOT_EMPTY_FLAG] = rx_not_empty_i;
   end

   always_comb begin
      rdv = 32'h0000_0000;
      if (spd_hit(adr_i, SPD_ISR_OFF)) rdv = {17'h0_0000, st_reg.isr};
      else if (spd_hit(adr_i, SPD_DMACR_OFF)) rdv = 32'h0000_0000;
      else if (spd_hit(adr_i, SPD_TXA_BEG_OFF)) rdv = {16'h0000, txba};
      else if (spd_hit(adr_i, SPD_TXB_BEG_OFF)) rdv = {16'h0000, txbb};
      else if (spd_hit(adr_i, SPD_TXA_END_OFF)) rdv = {16'h0000, txea};
      else if (spd_hit(adr_i, SPD_TXB_END_OFF)) rdv = {16'h0000, txeb};
      else if (spd_hit(adr_i, SPD_RXA_BEG_OFF)) rdv = {16'h0000, rxba};
      else if (spd_hit(adr_i, SPD_RXB_BEG_OFF)) rdv = {16'h0000, rxbb};
      else if (spd_hit(adr_i, SPD_RXA_END_OFF)) rdv = {16'h0000, rxea};
      else if (spd_hit(adr_i, SPD_RXB_END_OFF)) rdv = {16'h0000, rxeb};
      else if (spd_hit(adr_i, SPD_TXCNT_OFF)) rdv = {16'h0000, txc};
      else if (spd_hit(adr_i, SPD_RXCNTA_OFF)) rdv = {16'h0000, rxca};
      else if (spd_hit(adr_i, SPD_RXCNTB_OFF)) rdv = {16'h0000, rxcb};
      else if (spd_hit(adr_i, SPD_DMASR_OFF)) rdv = {26'h000_0000, rx_act, rx_ld, tx_act, tx_ld};
   end

   always_comb begin
      st_next = st_reg;
      st_next.ack = (wr || rd);
      st_next.push = 1'b0;
      st_next.pop = 1'b0;
      if (rd) st_next.rd = rdv;
      // software writes clear or keep; hardware set wins in the same cycle
      if (wr && spd_hit(adr_i, SPD_ISR_OFF)) begin
         if (sel_i[0]) st_next.isr[7:0] = st_reg.isr[7:0] & dat_i[7:0];
         if (sel_i[1]) st_next.isr[14:8] = st_reg.isr[14:8] & dat_i[14:8];
      end
      st_next.isr = st_next.isr | hw_set;
      // ram port arbitration, one request owns it until its ack
      if (!st_reg.busy) begin
         if (rx_req) begin
            st_next.gnt_rx = 1'b1;
            st_next.busy = 1'b1;
         end else if (tx_req) begin
            st_next.gnt_rx = 1'b0;
            st_next.busy = 1'b1;
         end
      end else if (mem_ack_i) begin
         st_next.busy = 1'b0;
      end
      if (tx_ack && st_reg.busy) begin
         st_next.txd = mem_rdata_i;
         st_next.push = 1'b1;
      end
      if (rx_ack && st_reg.busy) st_next.pop = 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.isr <= SPD_ISR_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ack_o = st_reg.ack;
   assign dat_o = st_reg.rd;
   assign tx_fifo_push_o = st_reg.push;
   assign tx_fifo_data_o = st_reg.txd;
   assign rx_fifo_pop_o = st_reg.pop;
   assign mem_req_o = st_reg.busy;
   assign mem_we_o = st_reg.busy && st_reg.gnt_rx;
   assign mem_addr_o = st_reg.gnt_rx ? rx_addr : tx_addr;
   assign mem_wdata_o = rx_fifo_data_i;

   a_unl_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_unl[1] |=> st_reg.isr[SPD_TXULB])
      else $error("tx b unload not flagged");
   a_rx_unl_set: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_unl[0] |=> st_reg.isr[SPD_RXULA])
      else $error("rx a unload not flagged");
   a_set_over_clr: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_done_i |=> st_reg.isr[SPD_CMDF])
      else $error("command done lost to clear");
   a_perr_set: assert property (@(posedge clk_i) disable iff (rst_i)
      par_err_i |=> st_reg.isr[SPD_PE])
      else $error("parity error not flagged");
   a_ovr_set: assert property (@(posedge clk_i) disable iff (rst_i)
      overrun_i |=> st_reg.isr[SPD_OVR])
      else $error("overrun not flagged");
   a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack held two cycles");
   a_pop_after_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      rx_fifo_pop_o |-> $past(mem_ack_i) && $past(mem_we_o))
      else $error("rx pop without ram write");
endmodule

// [tb/spd_mem_model.sv]
// Purpose: ram and serial fifo partner of the dma block
// Assumes: each held ram request gets one ack pulse
// Notes: slow_i adds wait cycles before each ack
`timescale 1ns/1ns
module spd_mem_model (
   // clock and bench controls
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic tx_en_i,
   input wire logic rx_en_i,
   // ram port
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [spd_pkg::SPD_MW-1:0] mem_addr_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o,
   output logic mem_ack_o,
   // fifo side
   input wire logic tx_push_i,
   input wire logic [7:0] tx_data_i,
   input wire logic rx_pop_i,
   output logic tx_room_o,
   output logic rx_avail_o,
   output logic [7:0] rx_data_o
);
   logic [7:0] mem [256];
   logic [7:0] rx_byte = 8'h40;
   logic [7:0] tx_q [$];
   int n_pop = 0;
   int wait_n = 0;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = i[7:0];
      end
      mem_ack_o = 1'b0;
      mem_rdata_o = 8'h00;
   end
   assign tx_room_o = tx_en_i;
   assign rx_avail_o = rx_en_i;
   // no head byte: show the inverse so a stale byte never passes
   assign rx_data_o = rx_en_i ? rx_byte : ~rx_byte;
   always @(posedge clk_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
         if (wait_n >= (slow_i ? 3 : 0)) begin
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem[mem_addr_i[7:0]];
            if (mem_we_i) begin
               mem[mem_addr_i[7:0]] <= mem_wdata_i;
            end
            wait_n <= 0;
         end else begin
            wait_n <= wait_n + 1;
         end
      end
      if (tx_push_i) begin
         tx_q.push_back(tx_data_i);
      end
      if (rx_pop_i) begin
         rx_byte <= rx_byte + 8'h01;
         n_pop <= n_pop + 1;
      end
   end
endmodule

// [tb/spd_top_tb.sv]
// Purpose: self-checking bench for the ping-pong dma and status register
// Assumes: wishbone answers within 20 cycles
// Notes: ram bytes start equal to their address
`timescale 1ns/1ns
module spd_top_tb;
   import spd_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic [15:0] adr_i = 16'h0000;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack_o;
   logic [10:0] ev = 11'h000;
   logic slow = 1'b0;
   logic tx_en = 1'b0;
   logic rx_en = 1'b0;
   logic tx_room, tx_push, rx_avail, rx_pop, mem_req, mem_we, mem_ack;
   logic [7:0] tx_data, rx_data, mem_wdata, mem_rdata;
   logic [15:0] mem_addr;
   logic [31:0] rd;
   logic [31:0] expv;
   int n_mismatch = 0;
   int n_compared = 0;
   int evb [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 13, 14};
   logic [7:0] tx_exp [6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21};
   logic [7:0] rx_adr [6] = '{8'h80, 8'h81, 8'h82, 8'ha0, 8'ha2, 8'ha3};
   logic [7:0] rx_exp [6] = '{8'h40, 8'h41, 8'h42, 8'ha0, 8'h43, 8'h44};

   spd_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .rx_not_empty_i(ev[0]), .tx_empty_i(ev[1]), .idle_line_i(ev[2]), .overrun_i(ev[3]),
      .underrun_i(ev[4]), .byte_got_i(ev[5]), .byte_sent_i(ev[6]), .cmd_done_i(ev[7]),
      .nack_i(ev[8]), .frm_err_i(ev[9]), .par_err_i(ev[10]), .tx_fifo_room_i(tx_room),
      .tx_fifo_push_o(tx_push), .tx_fifo_data_o(tx_data), .rx_fifo_avail_i(rx_avail),
      .rx_fifo_data_i(rx_data), .rx_fifo_pop_o(rx_pop), .mem_req_o(mem_req),
      .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
      .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
   spd_mem_model u_mdl (.clk_i(clk_i), .slow_i(slow), .tx_en_i(tx_en), .rx_en_i(rx_en),
      .mem_req_i(mem_req), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
      .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack),
      .tx_push_i(tx_push), .tx_data_i(tx_data), .rx_pop_i(rx_pop), .tx_room_o(tx_room),
      .rx_avail_o(rx_avail), .rx_data_o(rx_data));

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one classic cycle; read data lands in rd
   task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int k;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hf;
      adr_i <= a;
      dat_i <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_mismatch++;
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic poll(input logic [31:0] m);
      int k;
      k = 0;
      do begin
         wb(1'b0, SPD_ISR_OFF, 32'h0000_0000);
         k++;
      end while ((rd & m) !== m && k < 200);
   endtask

   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #2_000_000;
      n_mismatch++;
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, SPD_ISR_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      expv = 32'h0000_0000;
      for (int i = 0; i < 11; i++) begin
         ev <= 11'h001 << i;
         @(posedge clk_i);
         ev <= 11'h000;
         expv = expv | (32'h0000_0001 << evb[i]);
         wb(1'b0, SPD_ISR_OFF, 32'h0000_0000);
         chk(rd, expv);
      end
      wb(1'b1, SPD_ISR_OFF, 32'h0000_0000);
      wb(1'b1, SPD_ISR_OFF, 32'hffff_ffff);
      wb(1'b0, SPD_ISR_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      wb(1'b0, 16'ha9fc, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // transmit: a then b queued while the fifo has no room
      wb(1'b1, SPD_DMACR_OFF, 32'h0000_0010);
      wb(1'b1, SPD_TXA_BEG_OFF, 32'h0000_0010);
      wb(1'b1, SPD_TXA_END_OFF, 32'h0000_0013);
      wb(1'b1, SPD_TXB_BEG_OFF, 32'h0000_0020);
      wb(1'b1, SPD_TXB_END_OFF, 32'h0000_0021);
      wb(1'b1, SPD_DMACR_OFF, 32'h0000_0003);
      repeat (20) @(posedge clk_i);
      chk(32'(u_mdl.tx_q.size()), 32'h0000_0000);
      tx_en <= 1'b1;
      slow <= 1'b1;
      poll(32'h0000_1800);
      tx_en <= 1'b0;
      chk(rd, 32'h0000_1800);
      chk(32'(u_mdl.tx_q.size()), 32'h0000_0006);
      for (int i = 0; i < 6; i++) begin
         chk(32'(u_mdl.tx_q[i]), 32'(tx_exp[i]));
      end
      wb(1'b0, SPD_TXCNT_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      wb(1'b1, SPD_ISR_OFF, 32'h0000_0000);
      wb(1'b1, SPD_DMACR_OFF, 32'h0000_0001);
      wb(1'b0, SPD_TXCNT_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      wb(1'b1, SPD_TXA_END_OFF, 32'h0000_000f);
      poll(32'h0000_0800);
      chk(rd, 32'h0000_0800);
      wb(1'b1, SPD_TXA_END_OFF, 32'h0000_0013);
      wb(1'b1, SPD_DMACR_OFF, 32'h0000_0001);
      wb(1'b1, SPD_DMACR_OFF, 32'h0000_0010);
      tx_en <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(32'(u_mdl.tx_q.size()), 32'h0000_0006);
      tx_en <= 1'b0;
      // receive: a active, b loaded by its count write at offset 2
      wb(1'b1, SPD_ISR_OFF, 32'h0000_0000);
      wb(1'b1, SPD_DMACR_OFF, 32'h0000_0020);
      wb(1'b1, SPD_RXA_BEG_OFF, 32'h0000_0080);
      wb(1'b1, SPD_RXA_END_OFF, 32'h0000_0082);
      wb(1'b1, SPD_RXB_BEG_OFF, 32'h0000_00a0);
      wb(1'b1, SPD_RXB_END_OFF, 32'h0000_00a3);
      wb(1'b1, SPD_DMACR_OFF, 32'h0000_0004);
      wb(1'b1, SPD_RXCNTB_OFF, 32'h0000_0002);
      rx_en <= 1'b1;
      slow <= 1'b0;
      poll(32'h0000_0600);
      rx_en <= 1'b0;
      chk(rd, 32'h0000_0600);
      chk(32'(u_mdl.n_pop), 32'h0000_0005);
      for (int i = 0; i < 6; i++) begin
         chk(32'(u_mdl.mem[rx_adr[i]]), 32'(rx_exp[i]));
      end
      wb(1'b0, SPD_RXCNTA_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      wb(1'b0, SPD_RXCNTB_OFF, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      test_done();
   end
endmodule
